// ===== shared/motion_pkg.sv
// shared constants and types of the motion wake and sleep detector
package motion_pkg;

  // timing: fastest evaluation rate and the clock
  localparam int CLK_PERIOD_NS = 50;
  localparam int EVAL_FAST_PERIOD_NS = 10_000_000;
  localparam int FAST_TICK_CYCLES_DEF = EVAL_FAST_PERIOD_NS / CLK_PERIOD_NS;
  localparam int TICK_BASE_W = 24;
  localparam logic [6:0] OCTAVE_MASK_ALL = 7'h7F;

  // register byte offsets
  localparam logic [7:0] ADDR_MOTION_CTRL = 8'h00;
  localparam logic [7:0] ADDR_RATE_CTRL = 8'h04;
  localparam logic [7:0] ADDR_AXIS_DIR = 8'h08;
  localparam logic [7:0] ADDR_WAKE_DELAY = 8'h0C;
  localparam logic [7:0] ADDR_SLEEP_DELAY = 8'h10;
  localparam logic [7:0] ADDR_THRESH = 8'h14;
  localparam logic [7:0] ADDR_STATUS = 8'h18;

  // motion_control_reg bit positions
  localparam int CTL_WAKE_EN = 0;
  localparam int CTL_SLEEP_EN = 1;
  localparam int CTL_CNT_DEC = 2;
  localparam int CTL_REL = 3;
  localparam int CTL_PR = 4;
  localparam int CTL_FILT = 5;
  localparam int CTL_LATCH = 6;

  // field positions of rate, threshold and status registers
  localparam int RATE_WAKE_LSB = 0;
  localparam int RATE_SLEEP_LSB = 4;
  localparam int TH_WAKE_LSB = 0;
  localparam int TH_SLEEP_LSB = 16;
  localparam int ST_WAKE_CNT_LSB = 8;
  localparam int ST_SLEEP_CNT_LSB = 16;
  localparam int SAMPLE_TOP_LSB = 5;

  // engine indices
  localparam int ENG_WAKE = 0;
  localparam int ENG_SLEEP = 1;

  // values after reset
  localparam logic [7:0] CTRL_RST = 8'h40;
  localparam logic [7:0] RATE_RST = 8'h00;
  localparam logic [5:0] DIR_RST = 6'h3F;
  localparam logic [7:0] DELAY_RST = 8'h00;
  localparam logic [10:0] TH_RST = 11'h000;

  // bus answers
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // one acceleration sample, axis 2 = x, 1 = y, 0 = z
  typedef struct packed {
    logic [2:0][15:0] axis;
  } accel_t;

  // per-engine debounce state
  typedef struct packed {
    logic [2:0][10:0] prev;
    logic [2:0][10:0] refv;
    logic primed;
    logic hold;
    logic counting;
    logic [7:0] cnt;
    logic [2:0] sgn;
  } eng_t;

  typedef enum logic {WR_IDLE, WR_RESP} wr_state_t;

  // whole state of the top module
  typedef struct packed {
    wr_state_t wst;
    logic aw_have;
    logic w_have;
    logic [7:0] awaddr;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic [7:0] ctrl;
    logic [7:0] rate;
    logic [5:0] dir;
    logic [7:0] wake_dly;
    logic [7:0] sleep_dly;
    logic [10:0] wake_th;
    logic [10:0] sleep_th;
    accel_t raw;
    accel_t filt;
    logic [1:0] flag;
    eng_t [1:0] eng;
  } top_state_t;

  // state of the rate divider
  typedef struct packed {
    logic [TICK_BASE_W-1:0] base;
    logic [6:0] oct;
    logic tick;
  } tick_state_t;

endpackage

// ===== src/eval_tick.sv
// evaluation-rate divider: one-cycle tick at 100 Hz / 2^(7-rate)
`timescale 1ns/1ps
module eval_tick
  import motion_pkg::*;
#(
  parameter int TICK_CYCLES = FAST_TICK_CYCLES_DEF
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [2:0] rate_i,
  output logic tick_o
);

  tick_state_t st_r;
  tick_state_t st_nxt;

  // base counter makes the fastest rate, octave counter divides it down
  always_comb begin
    st_nxt = st_r;
    st_nxt.tick = 1'b0;
    if (st_r.base == TICK_BASE_W'(TICK_CYCLES - 1)) begin
      st_nxt.base = '0;
      st_nxt.oct = st_r.oct + 7'h01;
      if ((st_r.oct & (OCTAVE_MASK_ALL >> rate_i)) == 7'h00) begin
        st_nxt.tick = 1'b1;
      end
    end else begin
      st_nxt.base = st_r.base + TICK_BASE_W'(1);
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign tick_o = st_r.tick;

endmodule

// ===== src/axis_classify.sv
// per-axis threshold test with direction enables, absolute or relative
`timescale 1ns/1ps
module axis_classify (
  input wire logic [10:0] cur_i,
  input wire logic [10:0] base_i,
  input wire logic [10:0] th_i,
  input wire logic rel_i,
  input wire logic below_i,
  input wire logic pos_en_i,
  input wire logic neg_en_i,
  output logic hit_o,
  output logic neg_o
);

  logic signed [12:0] d;
  logic signed [12:0] md;
  logic signed [12:0] th;

  // difference to base in relative mode, raw value in absolute mode
  always_comb begin
    d = {{2{cur_i[10]}}, cur_i};
    if (rel_i) begin
      d = {{2{cur_i[10]}}, cur_i} - {{2{base_i[10]}}, base_i};
    end
    md = -d;
    th = {2'b00, th_i};
    neg_o = d[12];
    if (below_i) begin
      hit_o = (pos_en_i | neg_en_i) & ~(pos_en_i & (d >= th)) & ~(neg_en_i & (md >= th));
    end else begin
      hit_o = (pos_en_i & (d > th)) | (neg_en_i & (md > th));
    end
  end

endmodule

// ===== src/motion_detect.sv
// motion wake and sleep detector with AXI4-Lite register slave
//
// Chosen here: the placing of the registers and the AXI4-Lite slave port.
`timescale 1ns/1ps
module motion_detect
  import motion_pkg::*;
#(
  parameter int FAST_TICK_CYCLES = FAST_TICK_CYCLES_DEF
) (
  input wire logic CLK_I,
  input wire logic RESET_I,
  input wire logic [7:0] S_AXI_AWADDR_I,
  input wire logic S_AXI_AWVALID_I,
  output logic S_AXI_AWREADY_O,
  input wire logic [31:0] S_AXI_WDATA_I,
  input wire logic [3:0] S_AXI_WSTRB_I,
  input wire logic S_AXI_WVALID_I,
  output logic S_AXI_WREADY_O,
  output logic [1:0] S_AXI_BRESP_O,
  output logic S_AXI_BVALID_O,
  input wire logic S_AXI_BREADY_I,
  input wire logic [7:0] S_AXI_ARADDR_I,
  input wire logic S_AXI_ARVALID_I,
  output logic S_AXI_ARREADY_O,
  output logic [31:0] S_AXI_RDATA_O,
  output logic [1:0] S_AXI_RRESP_O,
  output logic S_AXI_RVALID_O,
  input wire logic S_AXI_RREADY_I,
  input wire accel_t SAMPLE_I,
  input wire accel_t FILT_I,
  input wire logic SAMPLE_VALID_I,
  output logic WAKE_INT_O,
  output logic SLEEP_INT_O
);

  top_state_t st_r;
  top_state_t st_nxt;
  wire logic [1:0] tick;
  wire logic [1:0][2:0] hit;
  wire logic [1:0][2:0] neg;
  logic [2:0][10:0] cur;
  logic [1:0] fire;

  // byte-lane merge of a write into an old register value
  function automatic logic [31:0] merge_strb(input logic [31:0] old_v, input logic [31:0] new_v,
                                             input logic [3:0] strb);
    logic [31:0] res;
    res = old_v;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        res[8*b +: 8] = new_v[8*b +: 8];
      end
    end
    return res;
  endfunction

  // tells whether an offset is one of ours
  function automatic logic addr_ok(input logic [7:0] a);
    return (a == ADDR_MOTION_CTRL) || (a == ADDR_RATE_CTRL) || (a == ADDR_AXIS_DIR) ||
           (a == ADDR_WAKE_DELAY) || (a == ADDR_SLEEP_DELAY) || (a == ADDR_THRESH) ||
           (a == ADDR_STATUS);
  endfunction

  // one evaluation tick per engine at its own selected rate
  eval_tick #(.TICK_CYCLES(FAST_TICK_CYCLES)) u_wake_tick (
    .clk_i(CLK_I),
    .rst_i(RESET_I),
    .rate_i(st_r.rate[RATE_WAKE_LSB +: 3]),
    .tick_o(tick[ENG_WAKE])
  );

  eval_tick #(.TICK_CYCLES(FAST_TICK_CYCLES)) u_sleep_tick (
    .clk_i(CLK_I),
    .rst_i(RESET_I),
    .rate_i(st_r.rate[RATE_SLEEP_LSB +: 3]),
    .tick_o(tick[ENG_SLEEP])
  );

  // source select and top 11 bits of the 32g-scaled data
  always_comb begin
    for (int a = 0; a < 3; a++) begin
      cur[a] = st_r.ctrl[CTL_FILT] ? st_r.filt.axis[a][15:SAMPLE_TOP_LSB]
                                   : st_r.raw.axis[a][15:SAMPLE_TOP_LSB];
    end
  end

  // threshold tests, one per engine and axis
  for (genvar e = 0; e < 2; e++) begin : g_eng
    for (genvar a = 0; a < 3; a++) begin : g_axis
      axis_classify u_cls (
        .cur_i(cur[a]),
        .base_i(st_r.eng[e].hold ? st_r.eng[e].refv[a] : st_r.eng[e].prev[a]),
        .th_i(e == ENG_WAKE ? st_r.wake_th : st_r.sleep_th),
        .rel_i(st_r.ctrl[CTL_REL]),
        .below_i(e == ENG_SLEEP),
        .pos_en_i(st_r.dir[2*a+1]),
        .neg_en_i(st_r.dir[2*a]),
        .hit_o(hit[e][a]),
        .neg_o(neg[e][a])
      );
    end
  end

  // next state: bus slave, registers, sample capture and both engines
  always_comb begin
    logic hit_eff;
    logic both;
    logic [7:0] dly;
    logic [31:0] wv;
    st_nxt = st_r;
    hit_eff = 1'b0;
    both = 1'b0;
    dly = 8'h00;
    wv = 32'h0000_0000;
    fire = 2'b00;
    // samples arrive at the data rate and are only held here
    if (SAMPLE_VALID_I) begin
      st_nxt.raw = SAMPLE_I;
      st_nxt.filt = FILT_I;
    end
    // non-latched events last one cycle
    if (!st_r.ctrl[CTL_LATCH]) begin
      st_nxt.flag = 2'b00;
    end
    // write address and data taken in either order
    if (S_AXI_AWVALID_I && st_r.awready) begin
      st_nxt.aw_have = 1'b1;
      st_nxt.awaddr = S_AXI_AWADDR_I;
    end
    if (S_AXI_WVALID_I && st_r.wready) begin
      st_nxt.w_have = 1'b1;
      st_nxt.wdata = S_AXI_WDATA_I;
      st_nxt.wstrb = S_AXI_WSTRB_I;
    end
    unique case (st_r.wst)
      WR_IDLE: begin
        if (st_r.aw_have && st_r.w_have) begin
          st_nxt.aw_have = 1'b0;
          st_nxt.w_have = 1'b0;
          st_nxt.bvalid = 1'b1;
          st_nxt.bresp = addr_ok(st_r.awaddr) ? RESP_OKAY : RESP_SLVERR;
          st_nxt.wst = WR_RESP;
          unique case (st_r.awaddr)
            ADDR_MOTION_CTRL: begin
              wv = merge_strb({24'h0, st_r.ctrl}, st_r.wdata, st_r.wstrb);
              st_nxt.ctrl = wv[7:0];
            end
            ADDR_RATE_CTRL: begin
              wv = merge_strb({24'h0, st_r.rate}, st_r.wdata, st_r.wstrb);
              st_nxt.rate = wv[7:0];
            end
            ADDR_AXIS_DIR: begin
              wv = merge_strb({26'h0, st_r.dir}, st_r.wdata, st_r.wstrb);
              st_nxt.dir = wv[5:0];
            end
            ADDR_WAKE_DELAY: begin
              wv = merge_strb({24'h0, st_r.wake_dly}, st_r.wdata, st_r.wstrb);
              st_nxt.wake_dly = wv[7:0];
            end
            ADDR_SLEEP_DELAY: begin
              wv = merge_strb({24'h0, st_r.sleep_dly}, st_r.wdata, st_r.wstrb);
              st_nxt.sleep_dly = wv[7:0];
            end
            ADDR_THRESH: begin
              wv = merge_strb({5'h0, st_r.sleep_th, 5'h0, st_r.wake_th}, st_r.wdata, st_r.wstrb);
              st_nxt.wake_th = wv[TH_WAKE_LSB +: 11];
              st_nxt.sleep_th = wv[TH_SLEEP_LSB +: 11];
            end
            ADDR_STATUS: begin
              if (st_r.wstrb[0]) begin
                st_nxt.flag = st_nxt.flag & ~st_r.wdata[1:0];
              end
            end
            default: begin
            end
          endcase
        end
      end
      WR_RESP: begin
        if (S_AXI_BREADY_I) begin
          st_nxt.bvalid = 1'b0;
          st_nxt.wst = WR_IDLE;
        end
      end
    endcase
    st_nxt.awready = !st_nxt.aw_have && (st_nxt.wst == WR_IDLE);
    st_nxt.wready = !st_nxt.w_have && (st_nxt.wst == WR_IDLE);
    // read: answer one cycle after the address is taken
    if (st_r.rvalid && S_AXI_RREADY_I) begin
      st_nxt.rvalid = 1'b0;
    end
    if (S_AXI_ARVALID_I && st_r.arready) begin
      st_nxt.rvalid = 1'b1;
      st_nxt.rresp = addr_ok(S_AXI_ARADDR_I) ? RESP_OKAY : RESP_SLVERR;
      unique case (S_AXI_ARADDR_I)
        ADDR_MOTION_CTRL: st_nxt.rdata = {24'h0, st_r.ctrl};
        ADDR_RATE_CTRL: st_nxt.rdata = {24'h0, st_r.rate};
        ADDR_AXIS_DIR: st_nxt.rdata = {26'h0, st_r.dir};
        ADDR_WAKE_DELAY: st_nxt.rdata = {24'h0, st_r.wake_dly};
        ADDR_SLEEP_DELAY: st_nxt.rdata = {24'h0, st_r.sleep_dly};
        ADDR_THRESH: st_nxt.rdata = {5'h0, st_r.sleep_th, 5'h0, st_r.wake_th};
        ADDR_STATUS: st_nxt.rdata = {8'h0, st_r.eng[ENG_SLEEP].cnt, st_r.eng[ENG_WAKE].cnt,
                                     6'h0, st_r.flag};
        default: st_nxt.rdata = 32'h0000_0000;
      endcase
    end
    st_nxt.arready = !st_nxt.rvalid;
    // engines: separate state, separate enable, separate rate
    for (int e = 0; e < 2; e++) begin
      dly = (e == ENG_WAKE) ? st_r.wake_dly : st_r.sleep_dly;
      if (!st_r.ctrl[e]) begin
        st_nxt.eng[e] = '0;
      end else if (tick[e]) begin
        hit_eff = 1'b0;
        for (int a = 0; a < 3; a++) begin
          both = st_r.dir[2*a+1] & st_r.dir[2*a];
          // with PR set and both directions on, a sign reversal during counting is a pulse and counts as a miss
          if (hit[e][a] && !(st_r.ctrl[CTL_PR] && both && st_r.eng[e].counting &&
                             neg[e][a] != st_r.eng[e].sgn[a])) begin
            hit_eff = 1'b1;
          end
        end
        // relative mode needs one earlier sample first
        if (st_r.ctrl[CTL_REL] && !st_r.eng[e].primed) begin
          hit_eff = 1'b0;
        end
        if (st_r.eng[e].counting && st_r.eng[e].cnt >= dly) begin
          fire[e] = 1'b1;
          st_nxt.eng[e].counting = 1'b0;
          st_nxt.eng[e].cnt = 8'h00;
          st_nxt.eng[e].hold = 1'b0;
        end else if (hit_eff) begin
          if (!st_r.eng[e].counting) begin
            st_nxt.eng[e].counting = 1'b1;
            st_nxt.eng[e].cnt = 8'h01;
            st_nxt.eng[e].hold = st_r.ctrl[CTL_REL];
            st_nxt.eng[e].refv = st_r.eng[e].prev;
            st_nxt.eng[e].sgn = neg[e];
          end else if (st_r.eng[e].cnt != 8'hFF) begin
            st_nxt.eng[e].cnt = st_r.eng[e].cnt + 8'h01;
          end
        end else if (st_r.eng[e].counting) begin
          if (st_r.ctrl[CTL_CNT_DEC] && st_r.eng[e].cnt > 8'h01) begin
            st_nxt.eng[e].cnt = st_r.eng[e].cnt - 8'h01;
          end else begin
            st_nxt.eng[e].counting = 1'b0;
            st_nxt.eng[e].cnt = 8'h00;
            st_nxt.eng[e].hold = 1'b0;
          end
        end
        st_nxt.eng[e].prev = cur;
        st_nxt.eng[e].primed = 1'b1;
      end
      // an event only sets its flag; configuration stays untouched, set beats clear
      if (fire[e]) begin
        st_nxt.flag[e] = 1'b1;
      end
    end
  end

  // state register
  always_ff @(posedge CLK_I or posedge RESET_I) begin
    if (RESET_I) begin
      st_r <= '0;
      st_r.ctrl <= CTRL_RST;
      st_r.rate <= RATE_RST;
      st_r.dir <= DIR_RST;
      st_r.wake_dly <= DELAY_RST;
      st_r.sleep_dly <= DELAY_RST;
      st_r.wake_th <= TH_RST;
      st_r.sleep_th <= TH_RST;
    end else begin
      st_r <= st_nxt;
    end
  end

  // outputs straight from the state register
  assign S_AXI_AWREADY_O = st_r.awready;
  assign S_AXI_WREADY_O = st_r.wready;
  assign S_AXI_BVALID_O = st_r.bvalid;
  assign S_AXI_BRESP_O = st_r.bresp;
  assign S_AXI_ARREADY_O = st_r.arready;
  assign S_AXI_RVALID_O = st_r.rvalid;
  assign S_AXI_RDATA_O = st_r.rdata;
  assign S_AXI_RRESP_O = st_r.rresp;
  assign WAKE_INT_O = st_r.flag[ENG_WAKE];
  assign SLEEP_INT_O = st_r.flag[ENG_SLEEP];

  // checks on the engines
  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (RESET_I);

  AST_CFG_UNTOUCHED: assert property (
    $rose(st_r.flag[ENG_WAKE]) |-> $stable(st_r.ctrl) && $stable(st_r.rate))
    else $error("wake event changed configuration");
  AST_DISABLED_IDLE: assert property (
    !st_r.ctrl[CTL_WAKE_EN] |=> st_r.eng[ENG_WAKE].cnt == 8'h00)
    else $error("disabled wake engine counts");
  AST_CLEAR_ON_MISS: assert property (
    tick[ENG_WAKE] && st_r.ctrl[CTL_WAKE_EN] && !st_r.ctrl[CTL_CNT_DEC] &&
    st_r.eng[ENG_WAKE].counting && st_r.eng[ENG_WAKE].cnt < st_r.wake_dly &&
    hit[ENG_WAKE] == 3'h0
    |=> st_r.eng[ENG_WAKE].cnt == 8'h00)
    else $error("miss did not clear counter");
  AST_DEC_ON_MISS: assert property (
    tick[ENG_WAKE] && st_r.ctrl[CTL_WAKE_EN] && st_r.ctrl[CTL_CNT_DEC] &&
    st_r.eng[ENG_WAKE].cnt > 8'h01 && st_r.eng[ENG_WAKE].cnt < st_r.wake_dly &&
    hit[ENG_WAKE] == 3'h0
    |=> st_r.eng[ENG_WAKE].cnt == $past(st_r.eng[ENG_WAKE].cnt) - 8'h01)
    else $error("miss did not decrement counter");
  AST_CNT_AT_TICK: assert property (
    !tick[ENG_WAKE] && st_r.ctrl[CTL_WAKE_EN] |=> $stable(st_r.eng[ENG_WAKE].cnt))
    else $error("wake counter moved off tick");
  AST_FIRE_NEXT_TICK: assert property (
    tick[ENG_WAKE] && st_r.ctrl[CTL_WAKE_EN] && st_r.eng[ENG_WAKE].counting &&
    st_r.eng[ENG_WAKE].cnt >= st_r.wake_dly |=> st_r.flag[ENG_WAKE] && !st_r.eng[ENG_WAKE].counting)
    else $error("wake event missing");
  AST_SLEEP_FIRE: assert property (
    $rose(st_r.flag[ENG_SLEEP]) |-> $past(tick[ENG_SLEEP]) && $past(st_r.eng[ENG_SLEEP].counting))
    else $error("sleep event without reached count");
  AST_LATCH_HOLD: assert property (
    st_r.ctrl[CTL_LATCH] && st_r.flag[ENG_WAKE] && !(st_r.wst == WR_IDLE && st_r.aw_have &&
    st_r.w_have && st_r.awaddr == ADDR_STATUS) |=> st_r.flag[ENG_WAKE])
    else $error("latched wake flag dropped");
  AST_REF_HELD: assert property (
    st_r.eng[ENG_WAKE].hold && !tick[ENG_WAKE] && st_r.ctrl[CTL_WAKE_EN]
    |=> $stable(st_r.eng[ENG_WAKE].refv))
    else $error("reference moved while held");
  AST_NO_UNDERFLOW: assert property (
    st_r.eng[ENG_WAKE].counting |-> st_r.eng[ENG_WAKE].cnt != 8'h00)
    else $error("counting with zero count");

endmodule

// ===== verification/host_model.sv
// host model: watches the motion interrupt lines and counts events
`timescale 1ns/1ps
module host_model (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wake_i,
  input wire logic sleep_i,
  output int wake_evt_o,
  output int sleep_evt_o
);
  logic wake_d;
  logic sleep_d;

  // a latched event counts once; software clears it before the next
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      wake_d <= 1'b0;
      sleep_d <= 1'b0;
      wake_evt_o <= 0;
      sleep_evt_o <= 0;
    end else begin
      wake_d <= wake_i;
      sleep_d <= sleep_i;
      if (wake_i && !wake_d) wake_evt_o <= wake_evt_o + 1;
      if (sleep_i && !sleep_d) sleep_evt_o <= sleep_evt_o + 1;
    end
  end
endmodule

// ===== verification/tb_top.sv
// self-checking bench of the motion detector against a behavioural model
`timescale 1ns/1ps
module tb_top;
  import motion_pkg::*;
  typedef struct {int ctl; int dr; int rt; int dly; int s0; int s1; int f; int m;} scen_t;
  localparam int FT = 4;
  logic clk, rst, awv, wv, bready, arv, rready, awr, wr, bv, arr, rv, wk, sl;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata, rdata, rd;
  logic [3:0] stb;
  logic [1:0] bresp, rresp, rs;
  accel_t smp, fsmp;
  int wev, sev, errors, compares, ew, es, b;
  scen_t sc [13];

  motion_detect #(.FAST_TICK_CYCLES(FT)) u_motion_detect (
    .CLK_I(clk), .RESET_I(rst),
    .S_AXI_AWADDR_I(awaddr), .S_AXI_AWVALID_I(awv), .S_AXI_AWREADY_O(awr),
    .S_AXI_WDATA_I(wdata), .S_AXI_WSTRB_I(stb), .S_AXI_WVALID_I(wv), .S_AXI_WREADY_O(wr),
    .S_AXI_BRESP_O(bresp), .S_AXI_BVALID_O(bv), .S_AXI_BREADY_I(bready),
    .S_AXI_ARADDR_I(araddr), .S_AXI_ARVALID_I(arv), .S_AXI_ARREADY_O(arr),
    .S_AXI_RDATA_O(rdata), .S_AXI_RRESP_O(rresp), .S_AXI_RVALID_O(rv),
    .S_AXI_RREADY_I(rready), .SAMPLE_I(smp), .FILT_I(fsmp), .SAMPLE_VALID_I(1'b1),
    .WAKE_INT_O(wk), .SLEEP_INT_O(sl));

  host_model u_host_model (.clk_i(clk), .rst_i(rst), .wake_i(wk), .sleep_i(sl),
    .wake_evt_o(wev), .sleep_evt_o(sev));

  // clock of 50 ns
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  task automatic close_out();
    $display("compares %0d errors %0d", compares, errors);
    if (errors == 0 && compares > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic chk_flag(input logic got, input logic exp);
    chk_word({31'h0, got}, {31'h0, exp});
  endtask

  // bounded wait: a hang counts as a mismatch and ends the run
  task automatic step(inout int n);
    n++;
    if (n > 200) begin
      errors++;
      close_out();
    end
  endtask

  // bus write: address and data offered together, each released when taken
  task automatic axw(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    int n;
    logic ta, tw;
    n = 0;
    @(posedge clk);
    awaddr <= a;
    wdata <= d;
    awv <= 1'b1;
    wv <= 1'b1;
    bready <= 1'b1;
    do begin
      @(negedge clk);
      ta = awv && awr;
      tw = wv && wr;
      @(posedge clk);
      if (ta) awv <= 1'b0;
      if (tw) wv <= 1'b0;
      step(n);
    end while ((awv && !ta) || (wv && !tw));
    do begin
      @(negedge clk);
      ta = bv;
      r = bresp;
      @(posedge clk);
      step(n);
    end while (!ta);
    bready <= 1'b0;
  endtask

  // bus read: answer taken at the edge where rvalid is seen
  task automatic axr(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    int n;
    logic t;
    n = 0;
    @(posedge clk);
    araddr <= a;
    arv <= 1'b1;
    rready <= 1'b1;
    do begin
      @(negedge clk);
      t = arv && arr;
      @(posedge clk);
      if (t) arv <= 1'b0;
      step(n);
    end while (!t);
    do begin
      @(negedge clk);
      t = rv;
      d = rdata;
      r = rresp;
      @(posedge clk);
      step(n);
    end while (!t);
    rready <= 1'b0;
  endtask

  // x axis value in threshold units; low five bits are noise below resolution
  task automatic drive(input int x, input int f);
    smp.axis[2] <= 16'(x * 32 + $urandom_range(0, 31));
    fsmp.axis[2] <= 16'(f * 32 + $urandom_range(0, 31));
  endtask

  // reference hit test of one engine, x carries v, y and z stay zero
  function automatic bit mhit(bit slp, int dr, int v, int th);
    bit h, p, q;
    int x;
    h = 0;
    for (int a = 0; a < 3; a++) begin
      p = dr[2*a+1];
      q = dr[2*a];
      x = (a == 2) ? v : 0;
      if (slp) h |= (p || q) && !(p && x >= th) && !(q && -x >= th);
      else h |= (p && x > th) || (q && -x > th);
    end
    return h;
  endfunction

  // configure, enable, watch both lines, then check latch and clear
  task automatic run(input scen_t s);
    int p, c, cw, v;
    bit xw, xs, fw, fs;
    // inputs only move on a rising edge
    @(posedge clk);
    p = FT << (7 - s.rt);
    v = s.ctl[5] ? s.f : (s.ctl[3] ? s.s1 - s.s0 : (s.m ? s.s0 : s.s1));
    xw = s.ctl[0] && mhit(0, s.dr, v, 64);
    xs = s.ctl[1] && mhit(1, s.dr, v, 32);
    fw = 0;
    fs = 0;
    cw = 0;
    drive(s.s0, s.f);
    axw(ADDR_RATE_CTRL, 32'(s.rt * 17), rs);
    axw(ADDR_AXIS_DIR, 32'(s.dr), rs);
    axw(ADDR_WAKE_DELAY, 32'(s.dly), rs);
    axw(ADDR_SLEEP_DELAY, 32'(s.dly), rs);
    axw(ADDR_MOTION_CTRL, 32'(s.ctl), rs);
    for (c = 0; c < (s.dly + 6) * p; c++) begin
      @(posedge clk);
      if (c == 3 * p) drive(s.s1, s.f);
      if (s.m && c == 4 * p) drive(s.s0, s.f); // one evaluation tick sees the miss
      @(negedge clk);
      if (!fw && wk === 1'b1) cw = c;
      fw |= (wk === 1'b1);
      fs |= (sl === 1'b1);
    end
    chk_flag(fw, xw);
    chk_flag(fs, xs);
    if (xw && s.s0 == s.s1) chk_flag(cw >= s.dly*p-3 && cw <= (s.dly+1)*p+2, 1'b1);
    // a decremented count needs two extra ticks, a cleared one a full delay again
    if (xw && s.m && s.ctl[2]) chk_flag(cw >= (s.dly+2)*p-1 && cw <= (s.dly+3)*p-2, 1'b1);
    if (xw && s.m && !s.ctl[2]) chk_flag(cw >= (s.dly+4)*p-2 && cw < (s.dly+6)*p, 1'b1);
    chk_flag(wk, xw);
    axr(ADDR_MOTION_CTRL, rd, rs);
    chk_word(rd, 32'(s.ctl));
    axr(ADDR_STATUS, rd, rs);
    chk_word(rd & 32'h3, {30'h0, xs, xw});
    axw(ADDR_MOTION_CTRL, 32'h40, rs);
    axw(ADDR_STATUS, 32'h3, rs);
    @(negedge clk);
    chk_flag(wk | sl, 1'b0);
    ew += xw;
    es += xs;
  endtask

  initial begin
    {awv, wv, bready, arv, rready} = '0;
    awaddr = 8'h00;
    araddr = 8'h00;
    wdata = 32'h0;
    stb = 4'hF;
    smp = '0;
    fsmp = '0;
    {errors, compares, ew, es} = '0;
    rst = 1'b1;
    void'($urandom(32));
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    // register values after reset, then unmapped places
    for (int i = 0; i < 7; i++) begin
      axr(8'(4 * i), rd, rs);
      chk_word(rd, i == 0 ? 32'(CTRL_RST) : (i == 2 ? 32'(DIR_RST) : 32'h0));
    end
    axr(8'h1C, rd, rs);
    chk_word(rd, 32'h0);
    chk_word(32'(rs), 32'(RESP_SLVERR));
    axw(8'h20, 32'hFFFFFFFF, rs);
    chk_word(32'(rs), 32'(RESP_SLVERR));
    // byte lanes: only the wake threshold half is written
    stb <= 4'h3;
    axw(ADDR_THRESH, 32'hFFFFFFFF, rs);
    stb <= 4'hF;
    axr(ADDR_THRESH, rd, rs);
    chk_word(rd, 32'h000007FF);
    axw(ADDR_THRESH, 32'h00200040, rs);
    b = 65 + $urandom_range(0, 200);
    sc = '{'{'h41, 'h3F, 7, 2, b, b, 0, 0},
      '{'h41, 'h3F, 6, 3, -b, -b, 0, 0},
      '{'h41, 'h2F, 7, 1, -b, -b, 0, 0},
      '{'h41, 'h1F, 7, 1, b, b, 0, 0},
      '{'h40, 'h3F, 7, 1, b, b, 0, 0},
      '{'h42, 'h3F, 7, 2, 0, 0, 0, 0},
      '{'h49, 'h3F, 7, 2, 0, b, 0, 0},
      '{'h49, 'h3F, 7, 2, b, b, 0, 0},
      '{'h61, 'h3F, 7, 2, 0, 0, b, 0},
      '{'h43, 'h3F, 7, 2, b, b, 0, 0},
      '{'h41, 'h3F, 7, 5, b, 0, 0, 1},
      '{'h45, 'h3F, 7, 5, b, 0, 0, 1},
      '{'h51, 'h3F, 7, 5, b, -b, 0, 1}};
    foreach (sc[i]) run(sc[i]);
    chk_word(32'(wev), 32'(ew));
    chk_word(32'(sev), 32'(es));
    close_out();
  end
endmodule
